// *** core/gpp_pkg.sv ***
// constants, types and register map of the general purpose i/o port
package gpp_pkg;
  localparam int unsigned GPP_NPINS = 8;
  localparam int unsigned GPP_AW = 9;

  // register byte offsets
  localparam logic [8:0] GPP_DIR = 9'h000;
  localparam logic [8:0] GPP_DIRSET = 9'h004;
  localparam logic [8:0] GPP_DIRCLR = 9'h008;
  localparam logic [8:0] GPP_DIRTGL = 9'h00C;
  localparam logic [8:0] GPP_OUT = 9'h010;
  localparam logic [8:0] GPP_OUTSET = 9'h014;
  localparam logic [8:0] GPP_OUTCLR = 9'h018;
  localparam logic [8:0] GPP_OUTTGL = 9'h01C;
  localparam logic [8:0] GPP_IN = 9'h020;
  localparam logic [8:0] GPP_INT0MASK = 9'h024;
  localparam logic [8:0] GPP_INT1MASK = 9'h028;
  localparam logic [8:0] GPP_INTFLAGS = 9'h02C;
  localparam logic [8:0] GPP_MPCMASK = 9'h030;
  localparam logic [8:0] GPP_CTRL = 9'h034;
  localparam logic [8:0] GPP_PINCFG0 = 9'h040;
  localparam logic [8:0] GPP_VDIR = 9'h0C0;
  localparam logic [8:0] GPP_VOUT = 9'h0C4;
  localparam logic [8:0] GPP_VIN = 9'h0C8;
  localparam logic [8:0] GPP_VFLAGS = 9'h0CC;
  localparam logic [8:0] GPP_BITWIN = 9'h100;

  // bit window groups
  localparam logic [2:0] GPP_BW_DIR = 3'h0;
  localparam logic [2:0] GPP_BW_OUT = 3'h1;
  localparam logic [2:0] GPP_BW_IN = 3'h2;
  localparam logic [2:0] GPP_BW_FLAGS = 3'h3;

  // ctrl field positions and the pins that clkout and evout drive
  localparam int unsigned GPP_CTRL_INT0LVL = 0;
  localparam int unsigned GPP_CTRL_INT1LVL = 2;
  localparam int unsigned GPP_CTRL_CLKOUT = 4;
  localparam int unsigned GPP_CTRL_EVOUT = 5;
  localparam int unsigned GPP_CLKOUT_PIN = 7;
  localparam int unsigned GPP_EVOUT_PIN = 6;

  // input sense configuration
  localparam logic [1:0] GPP_ISC_BOTH = 2'h0;
  localparam logic [1:0] GPP_ISC_RISE = 2'h1;
  localparam logic [1:0] GPP_ISC_FALL = 2'h2;
  localparam logic [1:0] GPP_ISC_LEVEL = 2'h3;

  // output configuration
  localparam logic [2:0] GPP_OPC_TOTEM = 3'h0;
  localparam logic [2:0] GPP_OPC_KEEPER = 3'h1;
  localparam logic [2:0] GPP_OPC_PULLDN = 3'h2;
  localparam logic [2:0] GPP_OPC_PULLUP = 3'h3;
  localparam logic [2:0] GPP_OPC_WOR = 3'h4;
  localparam logic [2:0] GPP_OPC_WAND = 3'h5;
  localparam logic [2:0] GPP_OPC_WOR_PD = 3'h6;
  localparam logic [2:0] GPP_OPC_WAND_PU = 3'h7;

  // reset values
  localparam logic [7:0] GPP_RST_BYTE = 8'h00;

  // pin configuration: inv at bit 5, opc at 4:2, isc at 1:0
  typedef struct packed {
    logic inv;
    logic [2:0] opc;
    logic [1:0] isc;
  } gpp_cfg_t;

  localparam gpp_cfg_t GPP_RST_CFG = 6'h00;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] pd;
  } gpp_pad_t;
endpackage

// *** core/gpp_port.sv ***
// general purpose i/o port: eight pins behind a classic wishbone slave
`timescale 1ns/10ps

module gpp_port
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [8:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // pads
  input wire logic [7:0] i_pad_in,
  output gpp_pad_t o_pad,
  // port clock present; low selects asynchronous sensing
  input wire logic i_port_clk_en,
  // alternate functions
  input wire logic [7:0] i_alt_en,
  input wire logic [7:0] i_alt_out,
  input wire logic [7:0] i_alt_oe,
  output logic [7:0] o_alt_in,
  // clock and event sources for pin output
  input wire logic i_clk_src,
  input wire logic i_evch7,
  // interrupt requests and wake-up
  output logic [1:0] o_irq,
  output logic [1:0] o_irq0_lvl,
  output logic [1:0] o_irq1_lvl,
  output logic o_wake
);

  function automatic logic [7:0] rmw(input logic [7:0] cur, input logic [7:0] wd,
                                     input logic [1:0] op);
    logic [7:0] r;
    r = cur;
    unique case (op)
      2'h0: r = wd;
      2'h1: r = cur | wd;
      2'h2: r = cur & ~wd;
      2'h3: r = cur ^ wd;
    endcase
    return r;
  endfunction

  function automatic logic sense_hit(input logic [1:0] isc, input logic cur,
                                     input logic old);
    logic h;
    h = 1'b0;
    unique case (isc)
      GPP_ISC_BOTH: h = cur ^ old;
      GPP_ISC_RISE: h = cur & ~old;
      GPP_ISC_FALL: h = ~cur & old;
      GPP_ISC_LEVEL: h = ~cur;
    endcase
    return h;
  endfunction

  logic [7:0] dir_reg;
  logic [7:0] out_reg;
  logic [7:0] mask0_reg;
  logic [7:0] mask1_reg;
  logic [7:0] mpc_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  gpp_cfg_t cfg_reg [GPP_NPINS];
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] prev_reg;
  logic [7:0] keep_reg;
  logic [7:0] alt_in_reg;
  gpp_pad_t pad_reg;
  gpp_pad_t pad_next;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rdata;

  logic [7:0] inv_vec;
  logic [7:0] sense;
  logic [7:0] evt;
  logic [7:0] wake_hit;
  logic [7:0] clr;
  logic wr;
  logic [7:0] wd;
  logic bw_hit;
  logic [2:0] bw_grp;
  logic [2:0] bw_bit;
  logic [7:0] bw_onehot;
  logic cfg_hit;
  logic [2:0] cfg_idx;

  // one write strobe at the edge the master samples ack
  assign wr = i_wb_cyc & i_wb_stb & i_wb_we & ack_reg & i_wb_sel[0];
  assign wd = i_wb_dat[7:0];
  assign bw_hit = (i_wb_adr[8] == 1'b1) && (i_wb_adr[7] == 1'b0);
  assign bw_grp = {1'b0, i_wb_adr[6:5]};
  assign bw_bit = i_wb_adr[4:2];
  assign bw_onehot = 8'h01 << bw_bit;
  assign cfg_hit = (i_wb_adr[8:5] == GPP_PINCFG0[8:5]);
  assign cfg_idx = i_wb_adr[4:2];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= i_wb_cyc & i_wb_stb & ~ack_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dat_reg <= 32'h00000000;
    end else if (i_wb_cyc & i_wb_stb & ~ack_reg) begin
      dat_reg <= rdata;
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = dat_reg;

  // direction: plain, set/clear/toggle aliases, virtual and bit windows
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dir_reg <= GPP_RST_BYTE;
    end else if (wr) begin
      if (i_wb_adr[8:4] == GPP_DIR[8:4]) begin
        dir_reg <= rmw(dir_reg, wd, i_wb_adr[3:2]);
      end else if (i_wb_adr == GPP_VDIR) begin
        dir_reg <= wd;
      end else if (bw_hit && bw_grp == GPP_BW_DIR) begin
        dir_reg <= wd[0] ? (dir_reg | bw_onehot) : (dir_reg & ~bw_onehot);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      out_reg <= GPP_RST_BYTE;
    end else if (wr) begin
      if (i_wb_adr[8:4] == GPP_OUT[8:4]) begin
        out_reg <= rmw(out_reg, wd, i_wb_adr[3:2]);
      end else if (i_wb_adr == GPP_VOUT) begin
        out_reg <= wd;
      end else if (bw_hit && bw_grp == GPP_BW_OUT) begin
        out_reg <= wd[0] ? (out_reg | bw_onehot) : (out_reg & ~bw_onehot);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mask0_reg <= GPP_RST_BYTE;
      mask1_reg <= GPP_RST_BYTE;
      ctrl_reg <= GPP_RST_BYTE;
    end else if (wr) begin
      if (i_wb_adr == GPP_INT0MASK) begin
        mask0_reg <= wd;
      end
      if (i_wb_adr == GPP_INT1MASK) begin
        mask1_reg <= wd;
      end
      if (i_wb_adr == GPP_CTRL) begin
        ctrl_reg <= wd;
      end
    end
  end

  // the multi-pin mask is consumed by the next pin config write
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mpc_reg <= GPP_RST_BYTE;
    end else if (wr && i_wb_adr == GPP_MPCMASK) begin
      mpc_reg <= wd;
    end else if (wr && cfg_hit) begin
      mpc_reg <= GPP_RST_BYTE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < GPP_NPINS; i++) begin
        cfg_reg[i] <= GPP_RST_CFG;
      end
    end else if (wr && cfg_hit) begin
      for (int i = 0; i < GPP_NPINS; i++) begin
        if (mpc_reg != GPP_RST_BYTE ? mpc_reg[i] : (cfg_idx == 3'(i))) begin
          cfg_reg[i] <= gpp_cfg_t'(wd[5:0]);
        end
      end
    end
  end

  // sensing: first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= GPP_RST_BYTE;
      sync2_reg <= GPP_RST_BYTE;
    end else begin
      sync1_reg <= i_pad_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < GPP_NPINS; i++) begin
      inv_vec[i] = cfg_reg[i].inv;
    end
  end

  assign sense = sync2_reg ^ inv_vec;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev_reg <= GPP_RST_BYTE;
      alt_in_reg <= GPP_RST_BYTE;
      keep_reg <= GPP_RST_BYTE;
    end else begin
      prev_reg <= sense;
      alt_in_reg <= sense;
      keep_reg <= sync2_reg;
    end
  end

  // asynchronous path compares the raw pad with the last sensed value;
  // it only speaks while the port clock is absent
  always_comb begin
    for (int i = 0; i < GPP_NPINS; i++) begin
      evt[i] = i_port_clk_en & sense_hit(cfg_reg[i].isc, sense[i], prev_reg[i]);
      wake_hit[i] = sense_hit(cfg_reg[i].isc, i_pad_in[i] ^ inv_vec[i], prev_reg[i]);
    end
  end

  assign o_wake = ~i_port_clk_en & |(wake_hit & (mask0_reg | mask1_reg));

  // flags clear by writing one; a new event in the same cycle wins
  always_comb begin
    clr = 8'h00;
    if (wr && (i_wb_adr == GPP_INTFLAGS || i_wb_adr == GPP_VFLAGS)) begin
      clr = wd;
    end else if (wr && bw_hit && bw_grp == GPP_BW_FLAGS && wd[0]) begin
      clr = bw_onehot;
    end
    flags_next = (flags_reg & ~clr) | evt;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_reg <= GPP_RST_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_irq[0] = |(flags_reg & mask0_reg);
  assign o_irq[1] = |(flags_reg & mask1_reg);
  assign o_irq0_lvl = ctrl_reg[GPP_CTRL_INT0LVL +: 2];
  assign o_irq1_lvl = ctrl_reg[GPP_CTRL_INT1LVL +: 2];

  // pad drive; pads are registered, so a clock output lags its source by one cycle
  always_comb begin
    logic src;
    logic v;
    logic d;
    logic [2:0] opc;
    src = 1'b0;
    v = 1'b0;
    d = 1'b0;
    opc = GPP_OPC_TOTEM;
    pad_next = '0;
    for (int i = 0; i < GPP_NPINS; i++) begin
      opc = cfg_reg[i].opc;
      src = out_reg[i];
      d = dir_reg[i];
      if (i == GPP_CLKOUT_PIN && ctrl_reg[GPP_CTRL_CLKOUT]) begin
        src = i_clk_src;
      end
      if (i == GPP_EVOUT_PIN && ctrl_reg[GPP_CTRL_EVOUT]) begin
        src = i_evch7;
      end
      if (i_alt_en[i]) begin
        src = i_alt_out[i];
        d = i_alt_oe[i];
      end
      v = src ^ cfg_reg[i].inv;
      if (opc == GPP_OPC_WAND || opc == GPP_OPC_WAND_PU) begin
        pad_next.oe[i] = d & ~v;
        pad_next.out[i] = 1'b0;
      end else if (opc == GPP_OPC_WOR || opc == GPP_OPC_WOR_PD) begin
        pad_next.oe[i] = d & v;
        pad_next.out[i] = 1'b1;
      end else begin
        pad_next.oe[i] = d;
        pad_next.out[i] = v;
      end
      pad_next.pu[i] = (opc == GPP_OPC_PULLUP) || (opc == GPP_OPC_WAND_PU)
                       || (opc == GPP_OPC_KEEPER && keep_reg[i]);
      pad_next.pd[i] = (opc == GPP_OPC_PULLDN) || (opc == GPP_OPC_WOR_PD)
                       || (opc == GPP_OPC_KEEPER && !keep_reg[i]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pad_reg <= '0;
    end else begin
      pad_reg <= pad_next;
    end
  end

  assign o_pad = pad_reg;
  assign o_alt_in = alt_in_reg;

  // read mux; unmapped addresses answer with zero
  always_comb begin
    rdata = 32'h00000000;
    if (cfg_hit) begin
      rdata[5:0] = cfg_reg[cfg_idx];
    end else if (bw_hit) begin
      unique case (bw_grp)
        GPP_BW_DIR: rdata[0] = dir_reg[bw_bit];
        GPP_BW_OUT: rdata[0] = out_reg[bw_bit];
        GPP_BW_IN: rdata[0] = sense[bw_bit];
        GPP_BW_FLAGS: rdata[0] = flags_reg[bw_bit];
        default: rdata[0] = 1'b0;
      endcase
    end else begin
      unique case (i_wb_adr)
        GPP_DIR, GPP_DIRSET, GPP_DIRCLR, GPP_DIRTGL, GPP_VDIR: rdata[7:0] = dir_reg;
        GPP_OUT, GPP_OUTSET, GPP_OUTCLR, GPP_OUTTGL, GPP_VOUT: rdata[7:0] = out_reg;
        GPP_IN, GPP_VIN: rdata[7:0] = sense;
        GPP_INT0MASK: rdata[7:0] = mask0_reg;
        GPP_INT1MASK: rdata[7:0] = mask1_reg;
        GPP_INTFLAGS, GPP_VFLAGS: rdata[7:0] = flags_reg;
        GPP_MPCMASK: rdata[7:0] = mpc_reg;
        GPP_CTRL: rdata[7:0] = ctrl_reg;
        default: rdata = 32'h00000000;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  logic [7:0] wand_vec;
  logic [7:0] keep_vec;
  logic [7:0] lvl_vec;
  logic [7:0] cfg0_bits;
  always_comb begin
    for (int i = 0; i < GPP_NPINS; i++) begin
      wand_vec[i] = cfg_reg[i].opc == GPP_OPC_WAND || cfg_reg[i].opc == GPP_OPC_WAND_PU;
      keep_vec[i] = cfg_reg[i].opc == GPP_OPC_KEEPER;
      lvl_vec[i] = cfg_reg[i].isc == GPP_ISC_LEVEL;
      cfg0_bits[i] = cfg_reg[i] == gpp_cfg_t'(wd[5:0]);
    end
  end

  sequence s_req;
    i_wb_cyc && i_wb_stb && !ack_reg;
  endsequence

  property p_ack;
    s_req |=> o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");

  property p_dirset;
    wr && i_wb_adr == GPP_DIRSET |=> dir_reg == ($past(dir_reg) | $past(wd));
  endproperty
  a_dirset: assert property (p_dirset) else $error("dir set alias wrong");

  property p_outtgl;
    wr && i_wb_adr == GPP_OUTTGL |=> out_reg == ($past(out_reg) ^ $past(wd));
  endproperty
  a_outtgl: assert property (p_outtgl) else $error("out toggle alias wrong");

  property p_mpc;
    wr && cfg_hit && mpc_reg != GPP_RST_BYTE |=> ((cfg0_bits | ~$past(mpc_reg)) == 8'hFF)
      && mpc_reg == GPP_RST_BYTE;
  endproperty
  a_mpc: assert property (p_mpc) else $error("multi-pin config missed a pin");

  property p_inv_in;
    $stable(inv_vec)[*3] |-> o_alt_in == ($past(i_pad_in, 3) ^ inv_vec);
  endproperty
  a_inv_in: assert property (p_inv_in) else $error("input inversion path wrong");

  property p_wand;
    (o_pad.oe & o_pad.out & $past(wand_vec)) == 8'h00;
  endproperty
  a_wand: assert property (p_wand) else $error("wired-and drove high");

  sequence s_low_src;
    i_port_clk_en && |(lvl_vec & mask0_reg & ~sense);
  endsequence

  property p_level;
    s_low_src |=> o_irq[0];
  endproperty
  a_level: assert property (p_level) else $error("low level irq dropped");

  property p_edge1;
    |(evt & mask1_reg) |=> o_irq[1];
  endproperty
  a_edge1: assert property (p_edge1) else $error("masked event gave no irq");

  property p_setwins;
    |(evt & clr) |=> (flags_reg & $past(evt)) == $past(evt);
  endproperty
  a_setwins: assert property (p_setwins) else $error("event lost on clear");

  property p_wake;
    !i_port_clk_en && |(lvl_vec & mask0_reg & ~(i_pad_in ^ inv_vec)) |-> o_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on low level");

  property p_keep;
    $stable(keep_vec)[*2] ##0 (keep_vec != 8'h00) |=>
      (o_pad.pu & $past(keep_vec)) == ($past(keep_reg) & $past(keep_vec));
  endproperty
  a_keep: assert property (p_keep) else $error("bus keeper level wrong");

endmodule

// *** test/gpp_pins.sv ***
// model of the circuitry at the port pins: external drivers, pulls and floating pads
`timescale 1ns/10ps

module gpp_pins
  import gpp_pkg::*;
(
  // clock
  input wire logic i_clk,
  // device side of the pads
  input wire gpp_pad_t i_pad,
  // external drivers
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  // resolved pad levels
  output logic [7:0] o_level
);
  logic [7:0] last_reg;

  always_ff @(posedge i_clk) begin
    last_reg <= o_level;
  end

  // an undriven, unpulled pad flips every cycle so a stale level never passes as valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (i_pad.oe[i]) begin
        o_level[i] = i_pad.out[i];
      end else if (i_ext_en[i]) begin
        o_level[i] = i_ext_val[i];
      end else if (i_pad.pu[i]) begin
        o_level[i] = 1'b1;
      end else if (i_pad.pd[i]) begin
        o_level[i] = 1'b0;
      end else begin
        o_level[i] = ~last_reg[i];
      end
    end
  end
endmodule

// *** test/gpp_tb.sv ***
// self-checking bench for the general purpose i/o port
`timescale 1ns/10ps

module testbench
  import gpp_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [8:0] wb_adr = 9'h000;
  logic [3:0] wb_sel = 4'hF;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] pad_in;
  gpp_pad_t pad;
  logic pclk = 1'b1;
  logic [7:0] alt_en = 8'h00;
  logic [7:0] alt_out = 8'h00;
  logic [7:0] alt_oe = 8'h00;
  logic [7:0] alt_in;
  logic clk_src = 1'b0;
  logic evch7 = 1'b0;
  logic [1:0] irq;
  logic [1:0] lvl0;
  logic [1:0] lvl1;
  logic wake;
  logic [7:0] ext_en = 8'hFF;
  logic [7:0] ext_val = 8'h00;
  int err_count = 0;
  int checks_done = 0;

  gpp_port u_dut (.i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_dat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_pad_in(pad_in), .o_pad(pad), .i_port_clk_en(pclk),
    .i_alt_en(alt_en), .i_alt_out(alt_out), .i_alt_oe(alt_oe), .o_alt_in(alt_in),
    .i_clk_src(clk_src), .i_evch7(evch7), .o_irq(irq), .o_irq0_lvl(lvl0),
    .o_irq1_lvl(lvl1), .o_wake(wake));

  gpp_pins u_pins (.i_clk(clk), .i_pad(pad), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .o_level(pad_in));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // request held until ack is sampled high; no fixed latency is assumed
  task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {24'h0, d};
    @(posedge clk);
    // only the watchdog ends a wait that never sees ack
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input string nm, input logic [8:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, q & m, e);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    logic [8:0] bases [2];
    bases[0] = GPP_DIR;
    bases[1] = GPP_OUT;
    tick(3);
    rst <= 1'b0;
    rdc("dir rst", GPP_DIR, 8'hFF, 8'h00);
    chk("oe rst", pad.oe, 8'h00);
    rdc("unmapped", 9'h038, 8'hFF, 8'h00);
    for (int b = 0; b < 2; b++) begin
      wr(bases[b], 8'h0F);
      wr(bases[b] + 9'h004, 8'h30);
      rdc("set", bases[b], 8'hFF, 8'h3F);
      wr(bases[b] + 9'h008, 8'h01);
      rdc("clr", bases[b], 8'hFF, 8'h3E);
      wr(bases[b] + 9'h00C, 8'hFF);
      rdc("tgl", bases[b], 8'hFF, 8'hC1);
    end
    tick(2);
    chk("oe dir", pad.oe, 8'hC1);
    chk("out", pad.out & 8'hC1, 8'hC1);
    wr(GPP_OUT, 8'h00);
    wr(GPP_MPCMASK, 8'h03);
    wr(GPP_PINCFG0, 8'h20);
    rdc("mpc cfg1", GPP_PINCFG0 + 9'h004, 8'h3F, 8'h20);
    rdc("mpc cfg2", GPP_PINCFG0 + 9'h008, 8'h3F, 8'h00);
    wr(GPP_DIR, 8'h03);
    tick(2);
    chk("inv out", pad.out & 8'h03, 8'h03);
    wr(GPP_DIR, 8'h00);
    ext_val[2] <= 1'b1;
    wr(GPP_PINCFG0 + 9'h008, 8'h21);
    tick(4);
    rdc("inv in", GPP_IN, 8'h04, 8'h00);
    wr(GPP_INT0MASK, 8'h04);
    wr(GPP_INTFLAGS, 8'hFF);
    ext_val[2] <= 1'b0;
    tick(5);
    rdc("inv edge", GPP_INTFLAGS, 8'h04, 8'h04);
    wr(GPP_INT0MASK, 8'h08);
    wr(GPP_INT1MASK, 8'h10);
    for (int m = 0; m < 4; m++) begin
      logic [1:0] sm;
      logic f;
      sm = 2'(m);
      f = (sm != GPP_ISC_RISE);
      ext_val[3] <= 1'b1;
      tick(5);
      wr(GPP_PINCFG0 + 9'h00C, {6'h0, sm});
      wr(GPP_INTFLAGS, 8'hFF);
      rdc("idle", GPP_INTFLAGS, 8'h08, 8'h00);
      ext_val[3] <= 1'b0;
      tick(5);
      rdc("fall", GPP_INTFLAGS, 8'h08, f ? 8'h08 : 8'h00);
      chk("irq", {6'h0, irq}, {7'h0, f});
      wr(GPP_INTFLAGS, 8'h08);
      rdc("low", GPP_INTFLAGS, 8'h08, (sm == GPP_ISC_LEVEL) ? 8'h08 : 8'h00);
      ext_val[3] <= 1'b1;
      tick(5);
      rdc("rise", GPP_INTFLAGS, 8'h08, (sm != GPP_ISC_FALL) ? 8'h08 : 8'h00);
    end
    wr(GPP_PINCFG0 + 9'h00C, 8'h00);
    pclk <= 1'b0;
    wr(GPP_INTFLAGS, 8'hFF);
    tick(2);
    chk("wake idle", {7'h0, wake}, 8'h00);
    ext_val[3] <= 1'b0;
    // the edge wake only stands until the sensed value catches up
    tick(1);
    chk("wake", {7'h0, wake}, 8'h01);
    rdc("no sync", GPP_INTFLAGS, 8'h08, 8'h00);
    wr(GPP_PINCFG0 + 9'h00C, 8'h03);
    tick(1);
    chk("wake low", {7'h0, wake}, 8'h01);
    pclk <= 1'b1;
    // pin 4 left undriven from outside so only the port can drive it
    ext_en[4] <= 1'b0;
    wr(GPP_PINCFG0 + 9'h010, 8'h14);
    wr(GPP_DIR, 8'h10);
    wr(GPP_OUT, 8'h10);
    tick(2);
    chk("wand hi", {7'h0, pad.oe[4]}, 8'h00);
    wr(GPP_OUTCLR, 8'h10);
    tick(2);
    chk("wand lo", {6'h0, pad.oe[4], pad.out[4]}, 8'h02);
    wr(GPP_PINCFG0 + 9'h010, 8'h10);
    wr(GPP_OUTSET, 8'h10);
    tick(2);
    chk("wor hi", {6'h0, pad.oe[4], pad.out[4]}, 8'h03);
    wr(GPP_OUTCLR, 8'h10);
    tick(2);
    chk("wor lo", {7'h0, pad.oe[4]}, 8'h00);
    wr(GPP_PINCFG0 + 9'h014, 8'h04);
    ext_val[5] <= 1'b1;
    tick(5);
    chk("keep hi", {6'h0, pad.pu[5], pad.pd[5]}, 8'h02);
    ext_val[5] <= 1'b0;
    tick(5);
    chk("keep lo", {6'h0, pad.pu[5], pad.pd[5]}, 8'h01);
    wr(GPP_PINCFG0 + 9'h014, 8'h20);
    alt_en <= 8'h20;
    alt_oe <= 8'h20;
    alt_out <= 8'h20;
    tick(6);
    chk("alt pad", {6'h0, pad.oe[5], pad.out[5]}, 8'h02);
    chk("alt in", alt_in & 8'h20, 8'h20);
    alt_en <= 8'h00;
    wr(GPP_CTRL, 8'h36);
    wr(GPP_DIR, 8'hC0);
    clk_src <= 1'b1;
    evch7 <= 1'b1;
    tick(4);
    chk("levels", {4'h0, lvl1, lvl0}, 8'h06);
    chk("src hi", pad.out & 8'hC0, 8'hC0);
    clk_src <= 1'b0;
    evch7 <= 1'b0;
    tick(4);
    chk("src lo", pad.out & 8'hC0, 8'h00);
    wr(GPP_BITWIN + 9'd48, 8'h01);
    rdc("bit out", GPP_OUT, 8'h10, 8'h10);
    rdc("bit dir", GPP_BITWIN + 9'd28, 8'h01, 8'h01);
    give_verdict();
  end
endmodule
